// >>> logic/sfe_cfg.svh
/*
 constants for the serial flash erase / power-down / id sequencer.
 assumes a 25 MHz system clock that oversamples the serial clock.
*/
`ifndef SFE_CFG_SVH
`define SFE_CFG_SVH
`define SFE_OP_WRITE_ENABLE_CMD 8'h06
`define SFE_OP_BLK 8'hD8
`define SFE_OP_CHIP_A 8'hC7
`define SFE_OP_CHIP_B 8'h60
`define SFE_OP_SLEEP 8'hB9
`define SFE_OP_WAKE 8'hAB
`define SFE_OP_MFID 8'h90
`define SFE_OP_RST 8'h99
`define SFE_CLK_MHZ 25
`define SFE_T_BLK_US 500000
`define SFE_T_CHIP_US 30000000
`define SFE_T_DP_US 3
`define SFE_WAKE_DELAY_US 3
`define SFE_WAKE_ID_DELAY_US 5
`define SFE_CYC(us) ((us) * `SFE_CLK_MHZ)
`define SFE_BLK_BITS 16
`endif

// >>> logic/sfe_pkg.sv
/*
 types for the serial flash sequencer.
 assumes sfe_cfg.svh is available on the include path.
*/
package sfe_pkg;
   typedef enum logic [2:0] {
      SFE_IDLE = 3'b000,
      SFE_ERASE = 3'b001,
      SFE_TO_SLEEP = 3'b010,
      SFE_SLEEP = 3'b011,
      SFE_WAKE = 3'b100
   } sfe_state_t;
endpackage

// >>> logic/sfe_top.sv
/*
 serial flash command sequencer: erase, deep sleep, id reads.
 assumes spi mode 0/3 pins sampled by CLK, array lives outside and is
 cleared through the erase request outputs.
*/
`timescale 1ns/1ps
`include "sfe_cfg.svh"
module sfe_top
   import sfe_pkg::*;
#(
   parameter int T_BLK_CYC = `SFE_CYC(`SFE_T_BLK_US),
   parameter int T_CHIP_CYC = `SFE_CYC(`SFE_T_CHIP_US)
) (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic SELECT_N,
   input wire logic SCLK,
   input wire logic SERIAL_IN,
   input wire logic PROTECT_COMPLEMENT,
   input wire logic SMALL_SECTOR_LOCK,
   input wire logic TOP_BOTTOM_SELECT,
   input wire logic [2:0] PROTECT_LEVEL,
   input wire logic PROG_SUSPENDED,
   input wire logic [7:0] DEVICE_ID,
   input wire logic [7:0] MANUF_ID,
   output logic SERIAL_OUT,
   output logic SERIAL_OUT_EN,
   output logic WRITE_LATCH_FLAG,
   output logic WRITE_BUSY_FLAG,
   output logic DEEP_SLEEP,
   output logic ERASE_BLOCK_REQ,
   output logic ERASE_CHIP_REQ,
   output logic [5:0] ERASE_BLOCK_NUM
);
   localparam int T_DP_CYC = `SFE_CYC(`SFE_T_DP_US);
   localparam int WAKE_DELAY_CYC = `SFE_CYC(`SFE_WAKE_DELAY_US);
   localparam int WAKE_ID_DELAY_CYC = `SFE_CYC(`SFE_WAKE_ID_DELAY_US);

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [2:0] cs_sy_ff, ck_sy_ff, di_sy_ff;
   logic cs_n_ff, ck_ff;
   // three stages; select and clock levels are accepted once the last two agree, data is taken from the last stage
   always_ff @(posedge CLK) begin
      if (SRST) begin
         cs_sy_ff <= 3'h7;
         ck_sy_ff <= 3'h0;
         di_sy_ff <= 3'h0;
         cs_n_ff <= 1'b1;
         ck_ff <= 1'b0;
      end else begin
         cs_sy_ff <= {cs_sy_ff[1:0], SELECT_N};
         ck_sy_ff <= {ck_sy_ff[1:0], SCLK};
         di_sy_ff <= {di_sy_ff[1:0], SERIAL_IN};
         if (cs_sy_ff[1] == cs_sy_ff[2]) cs_n_ff <= cs_sy_ff[2];
         if (ck_sy_ff[1] == ck_sy_ff[2]) ck_ff <= ck_sy_ff[2];
      end
   end
   logic ck_rise, ck_fall, cs_rise;
   logic ck_nxt, cs_nxt;
   assign ck_nxt = (ck_sy_ff[1] == ck_sy_ff[2]) ? ck_sy_ff[2] : ck_ff;
   assign cs_nxt = (cs_sy_ff[1] == cs_sy_ff[2]) ? cs_sy_ff[2] : cs_n_ff;
   assign ck_rise = !cs_n_ff && ck_nxt && !ck_ff;
   assign ck_fall = !cs_n_ff && !ck_nxt && ck_ff;
   assign cs_rise = cs_nxt && !cs_n_ff;

   // ------------------------------------------------------------
   // shift register and bit counter
   // ------------------------------------------------------------
   logic [31:0] shift_ff;
   logic [5:0] bits_ff;
   // decoder cleared whenever deselected, bits taken MSB first
   always_ff @(posedge CLK) begin
      if (SRST || cs_n_ff) begin
         shift_ff <= 32'h0;
         bits_ff <= 6'h0;
      end else if (ck_rise) begin
         shift_ff <= {shift_ff[30:0], di_sy_ff[2]};
         if (bits_ff != 6'h3F) bits_ff <= bits_ff + 6'h1;
      end
   end
   logic [7:0] opc_ff;
   always_ff @(posedge CLK) begin
      if (SRST || cs_n_ff) opc_ff <= 8'h0;
      else if (ck_rise && bits_ff == 6'h7) opc_ff <= {shift_ff[6:0], di_sy_ff[2]};
   end

   // ------------------------------------------------------------
   // protection decode (simplified: any nonzero level locks all)
   // ------------------------------------------------------------
   logic any_prot;
   // coarse map keeps the block small; partial protection treated as whole, except SMALL_SECTOR_LOCK alone under TOP_BOTTOM_SELECT stops chip erase only
   assign any_prot = (PROTECT_LEVEL != 3'h0) || PROTECT_COMPLEMENT || SMALL_SECTOR_LOCK;
   logic blk_prot;
   assign blk_prot = any_prot && !(TOP_BOTTOM_SELECT && PROTECT_LEVEL == 3'h0
                                   && !PROTECT_COMPLEMENT);

   // ------------------------------------------------------------
   // main state machine
   // ------------------------------------------------------------
   sfe_state_t state_ff;
   logic [31:0] tmr_ff;
   logic busy;
   assign busy = (state_ff == SFE_ERASE);
   logic erase_ok;
   assign erase_ok = WRITE_LATCH_FLAG && !PROG_SUSPENDED && !busy;
   logic go_blk, go_chip, go_dp, go_wake;
   assign go_blk = cs_rise && bits_ff == 6'd32 && opc_ff == `SFE_OP_BLK
                   && erase_ok && !blk_prot && state_ff == SFE_IDLE;
   assign go_chip = cs_rise && bits_ff == 6'd8 && state_ff == SFE_IDLE && erase_ok
                    && (opc_ff == `SFE_OP_CHIP_A || opc_ff == `SFE_OP_CHIP_B)
                    && !any_prot;
   assign go_dp = cs_rise && bits_ff == 6'd8 && opc_ff == `SFE_OP_SLEEP
                  && state_ff == SFE_IDLE;
   assign go_wake = cs_rise && bits_ff >= 6'd8 && opc_ff == `SFE_OP_WAKE
                    && (state_ff == SFE_SLEEP || state_ff == SFE_TO_SLEEP);
   logic go_rst;
   assign go_rst = cs_rise && bits_ff == 6'd8 && opc_ff == `SFE_OP_RST && !busy;

   always_ff @(posedge CLK) begin
      if (SRST) begin
         state_ff <= SFE_IDLE;
         tmr_ff <= 32'h0;
      end else begin
         case (state_ff)
            SFE_IDLE: begin
               if (go_blk) begin
                  state_ff <= SFE_ERASE;
                  tmr_ff <= 32'(T_BLK_CYC);
               end else if (go_chip) begin
                  state_ff <= SFE_ERASE;
                  tmr_ff <= 32'(T_CHIP_CYC);
               end else if (go_dp) begin
                  state_ff <= SFE_TO_SLEEP;
                  tmr_ff <= 32'(T_DP_CYC);
               end
            end
            SFE_ERASE: begin
               if (tmr_ff <= 32'h1) state_ff <= SFE_IDLE;
               tmr_ff <= tmr_ff - 32'h1;
            end
            SFE_TO_SLEEP, SFE_SLEEP: begin
               if (go_rst) begin
                  state_ff <= SFE_IDLE;
               end else if (go_wake) begin
                  state_ff <= SFE_WAKE;
                  tmr_ff <= (bits_ff == 6'd8) ? 32'(WAKE_DELAY_CYC) : 32'(WAKE_ID_DELAY_CYC);
               end else if (state_ff == SFE_TO_SLEEP) begin
                  if (tmr_ff <= 32'h1) state_ff <= SFE_SLEEP;
                  tmr_ff <= tmr_ff - 32'h1;
               end
            end
            SFE_WAKE: begin
               if (tmr_ff <= 32'h1) state_ff <= SFE_IDLE;
               tmr_ff <= tmr_ff - 32'h1;
            end
            default: state_ff <= SFE_IDLE;
         endcase
      end
   end
   assign WRITE_BUSY_FLAG = busy;
   assign DEEP_SLEEP = (state_ff == SFE_SLEEP);

   // ------------------------------------------------------------
   // write latch and erase strobes
   // ------------------------------------------------------------
   logic wel_ff;
   // latch set on a decoded write enable, dropped as the erase starts
   always_ff @(posedge CLK) begin
      if (SRST) wel_ff <= 1'b0;
      else if (go_blk || go_chip) wel_ff <= 1'b0;
      else if (cs_rise && bits_ff == 6'd8 && opc_ff == `SFE_OP_WRITE_ENABLE_CMD
               && state_ff == SFE_IDLE) wel_ff <= 1'b1;
   end
   assign WRITE_LATCH_FLAG = wel_ff;
   logic eb_ff, ec_ff;
   logic [5:0] bn_ff;
   always_ff @(posedge CLK) begin
      if (SRST) begin
         eb_ff <= 1'b0;
         ec_ff <= 1'b0;
         bn_ff <= 6'h0;
      end else begin
         eb_ff <= go_blk;
         ec_ff <= go_chip;
         if (go_blk) bn_ff <= shift_ff[21:16];
      end
   end
   assign ERASE_BLOCK_REQ = eb_ff;
   assign ERASE_CHIP_REQ = ec_ff;
   assign ERASE_BLOCK_NUM = bn_ff;

   // ------------------------------------------------------------
   // id output path
   // ------------------------------------------------------------
   logic [15:0] out_ff;
   logic out_on_ff;
   logic id_ok;
   // not decoded in a busy or wake cycle; awake or asleep both give the AB id, the 90 pair only when idle
   assign id_ok = !busy && state_ff != SFE_WAKE;
   always_ff @(posedge CLK) begin
      if (SRST || cs_n_ff) begin
         out_ff <= 16'h0;
         out_on_ff <= 1'b0;
      end else if (ck_fall && bits_ff == 6'd32 && !out_on_ff && id_ok) begin
         if (opc_ff == `SFE_OP_WAKE) begin
            out_ff <= {DEVICE_ID, DEVICE_ID};
            out_on_ff <= 1'b1;
         end else if (opc_ff == `SFE_OP_MFID && state_ff == SFE_IDLE) begin
            out_ff <= shift_ff[0] ? {DEVICE_ID, MANUF_ID}
                                  : {MANUF_ID, DEVICE_ID};
            out_on_ff <= 1'b1;
         end
      end else if (ck_fall && out_on_ff) begin
         // rotate so the pair repeats for as long as clocks come
         out_ff <= {out_ff[14:0], out_ff[15]};
      end
   end
   assign SERIAL_OUT = out_ff[15];
   assign SERIAL_OUT_EN = out_on_ff;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_blk_start;
      go_blk ##1 busy;
   endsequence
   chk_blk_busy: assert property (@(posedge CLK) disable iff (SRST)
      go_blk |=> busy && !wel_ff)
      else $error("block erase did not start busy");
   chk_blk_strobe: assert property (@(posedge CLK) disable iff (SRST)
      s_blk_start |-> ERASE_BLOCK_REQ)
      else $error("block erase strobe missing");
   chk_blk_wel: assert property (@(posedge CLK) disable iff (SRST)
      go_blk |-> wel_ff && !blk_prot && !PROG_SUSPENDED)
      else $error("erase started without latch");
   chk_chip_prot: assert property (@(posedge CLK) disable iff (SRST)
      ERASE_CHIP_REQ |-> !$past(any_prot))
      else $error("chip erase while protected");
   chk_dp_busy: assert property (@(posedge CLK) disable iff (SRST)
      busy && cs_rise |=> state_ff != SFE_TO_SLEEP)
      else $error("sleep accepted while busy");
   chk_wel_end: assert property (@(posedge CLK) disable iff (SRST)
      $fell(busy) |-> !wel_ff)
      else $error("latch still set at erase end");
   chk_dp_enter: assert property (@(posedge CLK) disable iff (SRST)
      go_dp |=> state_ff == SFE_TO_SLEEP)
      else $error("sleep entry missed");
   chk_out_desel: assert property (@(posedge CLK) disable iff (SRST)
      cs_n_ff |=> !SERIAL_OUT_EN)
      else $error("output driven while deselected");
   chk_chip_busy: assert property (@(posedge CLK) disable iff (SRST)
      go_chip |=> busy && !wel_ff && ERASE_CHIP_REQ)
      else $error("chip erase did not start busy");
   chk_id_busy: assert property (@(posedge CLK) disable iff (SRST)
      busy && !SERIAL_OUT_EN |=> !SERIAL_OUT_EN)
      else $error("id output started in busy cycle");
   chk_wake_enter: assert property (@(posedge CLK) disable iff (SRST)
      go_wake |=> state_ff == SFE_WAKE && !DEEP_SLEEP)
      else $error("wake from deep sleep missed");
endmodule

// >>> verification/sfe_host_model.sv
/*
 host spi controller model driving the flash sequencer pins.
 assumes clk is the bench system clock; sclk runs at clk/8 (320 ns), mode 0.
*/
`timescale 1ns/1ps
module sfe_host_model (
   input wire logic clk,
   output logic select_n,
   output logic sclk,
   output logic serial_in,
   input wire logic serial_out
);
   initial begin
      select_n = 1'b1;
      sclk = 1'b0;
      serial_in = 1'b0;
   end
   // one frame: nw bits of cmd msb first, then nr bits read back
   // sclk stands low outside frames; read bits are taken late in the high phase
   task automatic frame(input logic [31:0] cmd, input int nw, input int nr,
                        output logic [15:0] rd);
      rd = 16'h0000;
      @(posedge clk);
      select_n <= 1'b0;
      for (int i = 0; i < nw + nr; i++) begin
         serial_in <= (i < nw) ? cmd[nw - 1 - i] : 1'b0;
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
         repeat (4) @(posedge clk);
         if (i >= nw) rd = {rd[14:0], serial_out};
         sclk <= 1'b0;
      end
      repeat (4) @(posedge clk);
      // released data line flips so a stale level is never mistaken for data
      select_n <= 1'b1;
      serial_in <= ~serial_in;
   endtask
endmodule

// >>> verification/sfe_top_tb.sv
/*
 self-checking bench for sfe_top: erase, deep sleep and id reads.
 assumes the host model above and shortened erase times.
*/
`timescale 1ns/1ps
module sfe_top_tb;
   import sfe_pkg::*;
   localparam int TBLK = 600;
   localparam int TCHIP = 300;
   localparam logic [7:0] DEV = 8'h5A; // arbitrary value
   localparam logic [7:0] MAN = 8'hA7; // arbitrary value
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic sel_n, sclk, sdi, so, so_en, write_latch_flag, write_busy_flag, dsleep, blk_req, chip_req;
   logic cmp = 1'b0;
   logic ssl = 1'b0;
   logic tbs = 1'b0;
   logic [2:0] lvl = 3'h0;
   logic susp = 1'b0;
   logic [5:0] bnum;
   logic [15:0] rd;
   logic blk_seen = 1'b0;
   logic chip_seen = 1'b0;
   logic en_seen = 1'b0;
   logic seen_clr = 1'b0;
   int fails = 0;
   int check_count = 0;
   always #20 clk = ~clk;
   // request pulses last one cycle, so keep a sticky copy
   always @(posedge clk) begin
      if (seen_clr) begin
         blk_seen <= 1'b0;
         chip_seen <= 1'b0;
         en_seen <= 1'b0;
      end else begin
         if (blk_req === 1'b1) blk_seen <= 1'b1;
         if (chip_req === 1'b1) chip_seen <= 1'b1;
         if (so_en === 1'b1) en_seen <= 1'b1;
      end
   end
   sfe_host_model i_sfe_host_model (.clk(clk), .select_n(sel_n), .sclk(sclk),
      .serial_in(sdi), .serial_out(so));
   sfe_top #(.T_BLK_CYC(TBLK), .T_CHIP_CYC(TCHIP)) i_sfe_top (.CLK(clk),
      .SRST(srst), .SELECT_N(sel_n), .SCLK(sclk), .SERIAL_IN(sdi),
      .PROTECT_COMPLEMENT(cmp), .SMALL_SECTOR_LOCK(ssl), .TOP_BOTTOM_SELECT(tbs),
      .PROTECT_LEVEL(lvl), .PROG_SUSPENDED(susp), .DEVICE_ID(DEV), .MANUF_ID(MAN),
      .SERIAL_OUT(so), .SERIAL_OUT_EN(so_en), .WRITE_LATCH_FLAG(write_latch_flag),
      .WRITE_BUSY_FLAG(write_busy_flag), .DEEP_SLEEP(dsleep), .ERASE_BLOCK_REQ(blk_req),
      .ERASE_CHIP_REQ(chip_req), .ERASE_BLOCK_NUM(bnum));
   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      chk_val({15'h0000, got}, {15'h0000, exp});
   endtask
   // bounded wait on busy or sleep; a hang ends the run as a mismatch
   task automatic wait_sig(input logic slp, input logic v, input int lim);
      int n;
      n = 0;
      while (((slp ? dsleep : write_busy_flag) !== v) && n < lim) begin
         @(posedge clk);
         n++;
      end
      chk_flag(slp ? dsleep : write_busy_flag, v);
      if ((slp ? dsleep : write_busy_flag) !== v) tally_and_finish();
   endtask
   task automatic go(input logic [31:0] cmd, input int nw, input int nr);
      seen_clr <= 1'b1;
      @(posedge clk);
      seen_clr <= 1'b0;
      i_sfe_host_model.frame(cmd, nw, nr, rd);
      repeat (8) @(posedge clk);
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      repeat (4) @(posedge clk);
      chk_flag(dsleep, 1'b0);
      chk_flag(write_latch_flag, 1'b0);
      go(32'hD82A1234, 32, 0);
      chk_flag(blk_seen, 1'b0);
      go(32'h06, 8, 0);
      chk_flag(write_latch_flag, 1'b1);
      go(32'hD82A1234, 32, 0);
      chk_flag(blk_seen, 1'b1);
      chk_val({10'h000, bnum}, 16'h002A);
      chk_flag(write_busy_flag, 1'b1);
      chk_flag(write_latch_flag, 1'b0);
      go(32'hB9, 8, 0);
      go(32'hAB000000, 32, 8);
      chk_val(rd, 16'h0000);
      chk_flag(en_seen, 1'b0);
      wait_sig(1'b0, 1'b0, TBLK);
      chk_flag(dsleep, 1'b0);
      $display("test block erase done");
      go(32'h06, 8, 0);
      go(32'hD82A1234 >> 1, 31, 0);
      chk_flag(blk_seen, 1'b0);
      for (int i = 0; i < 2; i++) begin
         go(32'h06, 8, 0);
         go(i ? 32'h60 : 32'hC7, 8, 0);
         chk_flag(chip_seen, 1'b1);
         wait_sig(1'b0, 1'b0, TCHIP);
      end
      lvl <= 3'h1;
      go(32'h06, 8, 0);
      go(32'hC7, 8, 0);
      chk_flag(chip_seen, 1'b0);
      go(32'hD83F0000, 32, 0);
      chk_flag(blk_seen, 1'b0);
      lvl <= 3'h0;
      susp <= 1'b1;
      go(32'hD8000000, 32, 0);
      chk_flag(blk_seen, 1'b0);
      go(32'h60, 8, 0);
      chk_flag(blk_seen | chip_seen, 1'b0);
      susp <= 1'b0;
      $display("test erase refusals done");
      go(32'hAB000000, 32, 16);
      chk_val(rd, {DEV, DEV});
      chk_flag(en_seen, 1'b1);
      chk_flag(so_en, 1'b0);
      chk_flag(dsleep, 1'b0);
      go(32'h90000000, 32, 16);
      chk_val(rd, {MAN, DEV});
      go(32'h90000001, 32, 16);
      chk_val(rd, {DEV, MAN});
      $display("test id reads done");
      go(32'hB9, 8, 0);
      wait_sig(1'b1, 1'b1, 200);
      go(32'h06, 8, 0);
      go(32'hD8000000, 32, 0);
      chk_flag(blk_seen | write_busy_flag, 1'b0);
      go(32'hAB, 8, 0);
      wait_sig(1'b1, 1'b0, 200);
      repeat (150) @(posedge clk);
      go(32'hB9, 8, 0);
      wait_sig(1'b1, 1'b1, 200);
      go(32'hAB000000, 32, 16);
      chk_val(rd, {DEV, DEV});
      wait_sig(1'b1, 1'b0, 250);
      repeat (150) @(posedge clk);
      $display("test deep sleep done");
      tally_and_finish();
   end
endmodule
